// *** fixed_point_consts.svh ***
`ifndef FIXED_POINT_CONSTS_SVH
`define FIXED_POINT_CONSTS_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define WORD_W        40
`define FRAC_W        39
`define SIGN_BIT      39
`define ROUND_BIT     0
`define WORD_RESET    40'h00_0000_0000

// ----------------------------------------------------------------
// Shift and multiply counts
// ----------------------------------------------------------------
`define SHIFT_MAX     6'h28
`define MUL_STEPS     6'h27

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_SHIFT_LEFT  3'h0
`define OP_SHIFT_RIGHT 3'h1
`define OP_ADD         3'h2
`define OP_SUB         3'h3
`define OP_NEGATE      3'h4
`define OP_MUL         3'h5
`define OP_MUL_ROUND   3'h6

`endif

// *** fixed_point_pkg.sv ***
`default_nettype none

package fixed_point_pkg;

  typedef logic [39:0] word_t;
  typedef logic [38:0] frac_t;

  typedef enum logic [1:0] {
    st_idle,
    st_mul_step,
    st_mul_fix
  } state_t;

  typedef struct packed {
    state_t      state;
    logic        done;
    word_t       result;
    word_t       low;
    word_t       acc;
    frac_t       mq;
    word_t       y;
    logic        x_sign;
    logic        round;
    logic        first_one;
    logic [5:0]  step;
  } regs_t;

endpackage

`default_nettype wire

// *** fixed_point_shift_add_mul.sv ***
// Operation
// RULE1 - Shifts left or right by zero to forty places, larger counts clamp.
// RULE2 - Left shift moves the first fraction bit into the sign position.
// RULE3 - Right shift fills vacated high positions with the sign bit.
// RULE4 - Right shift truncates; shifted-out bits appear on the low output.
// RULE5 - Shifts treat the forty-bit word as one aggregate.
// RULE6 - Adder sums modulo two, dropping the carry out of the sign.
// RULE7 - Negation inverts every bit then adds one at the lowest bit.
// RULE8 - Subtraction adds the complement of the subtrahend with the same adder.
// RULE9 - Multiply gives sign plus seventy-eight fraction bits over two words.
// RULE10 - Binary point sits right after the sign for all operands and results.
// RULE11 - Multiply scans only the thirty-nine multiplier fraction bits.
// RULE12 - Negative multiplier leaves an extra multiplicand term to remove.
// RULE13 - Forty steps: thirty-nine add-and-shift, then complement add if negative.
// RULE14 - After the first multiplier one, partial sign equals multiplicand sign.
// RULE15 - Rounded multiply sets the thirty-ninth product fraction bit to one.
// RULE16 - Values span minus one to below one; one then zeros is minus one.
// RULE17 - Left shift fills low bits with zeros and drops bits past the sign; the code puts those bits on the low output instead.
`include "fixed_point_consts.svh"
`default_nettype none

module fixed_point_shift_add_mul (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        op_valid,
  input  wire logic [2:0]  op_code,
  input  wire logic [39:0] operand_a,
  input  wire logic [39:0] operand_b,
  input  wire logic [5:0]  shift_count,
  output logic             op_ready,
  output logic             result_valid,
  output logic [39:0]      result,
  output logic [39:0]      result_low
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fixed_point_pkg::regs_t s;
  fixed_point_pkg::regs_t next_s;

  shift_bus_if sb ();

  shift_unit u_shift (
    .sb (sb.shifter)
  );

  assign sb.value = operand_a;
  assign sb.count = shift_count;
  assign sb.right = (op_code == `OP_SHIFT_RIGHT);

  // ----------------------------------------------------------------
  // Shared adder terms
  // ----------------------------------------------------------------
  fixed_point_pkg::word_t alu_a;
  fixed_point_pkg::word_t alu_b;
  logic                   alu_cin;
  fixed_point_pkg::word_t alu_sum;
  fixed_point_pkg::word_t step_sum;
  fixed_point_pkg::word_t fix_sum;
  logic                   step_bit;

  always_comb begin
    alu_a   = operand_a;
    alu_b   = operand_b;
    alu_cin = 1'b0;
    unique case (op_code)
      `OP_SUB: begin
        alu_b   = ~operand_b; // RULE8
        alu_cin = 1'b1; // RULE8
      end
      `OP_NEGATE: begin
        alu_a   = `WORD_RESET;
        alu_b   = ~operand_b; // RULE7
        alu_cin = 1'b1; // RULE7
      end
      default: begin
        alu_a   = operand_a;
      end
    endcase
  end

  // Forty-bit result cuts the carry out of the sign; minus one negates to itself
  assign alu_sum = 40'(alu_a + alu_b + {39'h0, alu_cin}); // RULE6 RULE16

  // One multiply step examines the lowest unscanned fraction bit
  assign step_bit = s.mq[0]; // RULE11
  assign step_sum = 40'(s.acc + (step_bit ? s.y : `WORD_RESET)); // RULE13 RULE6

  // Removing the extra multiplicand term left by a negative multiplier
  assign fix_sum  = 40'(s.acc + ~s.y + 40'h00_0000_0001); // RULE12 RULE13

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    unique case (s.state)
      fixed_point_pkg::st_idle: begin
        if (op_valid) begin
          unique case (op_code)
            `OP_SHIFT_LEFT, `OP_SHIFT_RIGHT: begin
              next_s.result = sb.result; // RULE1
              next_s.low    = sb.spill; // RULE4
              next_s.done   = 1'b1;
            end
            `OP_ADD, `OP_SUB, `OP_NEGATE: begin
              next_s.result = alu_sum; // RULE6
              next_s.low    = `WORD_RESET;
              next_s.done   = 1'b1;
            end
            `OP_MUL, `OP_MUL_ROUND: begin
              // Sign bit of the multiplier is kept apart, never scanned
              next_s.mq        = operand_a[38:0]; // RULE11
              next_s.x_sign    = operand_a[`SIGN_BIT]; // RULE12
              next_s.y         = operand_b;
              next_s.acc       = `WORD_RESET;
              next_s.round     = (op_code == `OP_MUL_ROUND);
              next_s.first_one = 1'b0;
              next_s.step      = 6'h00;
              next_s.state     = fixed_point_pkg::st_mul_step;
            end
            default: begin
              // Unused code is taken and dropped with no answer
              next_s.done = 1'b0;
            end
          endcase
        end
      end
      fixed_point_pkg::st_mul_step: begin
        // Sum shifted right one; sign held to the multiplicand after first one
        if (step_bit || s.first_one) begin
          next_s.acc = {s.y[`SIGN_BIT], step_sum[39:1]}; // RULE14
        end else begin
          next_s.acc = {step_sum[`SIGN_BIT], step_sum[39:1]};
        end
        next_s.first_one = s.first_one | step_bit; // RULE14
        next_s.mq        = {step_sum[0], s.mq[38:1]}; // RULE13 RULE9
        next_s.step      = 6'(s.step + 6'h01);
        if (s.step == 6'(`MUL_STEPS - 6'h01)) begin
          next_s.state = fixed_point_pkg::st_mul_fix; // RULE11
        end
      end
      fixed_point_pkg::st_mul_fix: begin
        next_s.result = s.x_sign ? fix_sum : s.acc; // RULE13 RULE12
        next_s.low    = {s.mq, 1'b0}; // RULE9 RULE10
        if (s.round) begin
          // Round-off discards the low half rather than carrying it up
          next_s.result[`ROUND_BIT] = 1'b1; // RULE15
          next_s.low                = `WORD_RESET; // RULE15
        end
        next_s.done  = 1'b1;
        next_s.state = fixed_point_pkg::st_idle;
      end
      default: begin
        next_s.state = fixed_point_pkg::st_idle;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Busy for the whole multiply so operands need only stand one cycle
  assign op_ready     = (s.state == fixed_point_pkg::st_idle);
  assign result_valid = s.done;
  assign result       = s.result; // RULE10
  assign result_low   = s.low; // RULE9

endmodule // fixed_point_shift_add_mul

`default_nettype wire

// *** fixed_point_shift_add_mul_assertions.sv ***
`default_nettype none
// ------------------------------
// Port checks
// ------------------------------
module shift_add_mul_checker (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        op_valid,
  input wire logic [2:0]  op_code,
  input wire logic [39:0] operand_a,
  input wire logic [39:0] operand_b,
  input wire logic [5:0]  shift_count,
  input wire logic        op_ready,
  input wire logic        result_valid,
  input wire logic [39:0] result,
  input wire logic [39:0] result_low
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = op_valid && op_ready;
  wire mul = op_code == 3'h5 || op_code == 3'h6;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  single_latency_a: assert property (take && op_code < 3'h5 |=> result_valid)
    else $error("single op answer late");
  mul_latency_a: assert property (take && mul |-> ##41 result_valid)
    else $error("multiply answer not at 41");
  mul_busy_a: assert property (take && mul |=> !op_ready [*8])
    else $error("ready during multiply");
  shift_left_a: assert property (take && op_code == 3'h0
    |=> result == ($past(operand_a) << $past(shift_count))) else $error("left shift wrong");
  shift_right_a: assert property (take && op_code == 3'h1
    |=> $signed(result) == ($signed($past(operand_a)) >>> $past(shift_count)))
    else $error("right shift");
  add_mod_a: assert property (take && op_code == 3'h2
    |=> result == $past(operand_a) + $past(operand_b)) else $error("sum wrong");
  sub_mod_a: assert property (take && op_code == 3'h3
    |=> result == $past(operand_a) - $past(operand_b)) else $error("difference wrong");
  negate_op_a: assert property (take && op_code == 3'h4
    |=> result == ~$past(operand_b) + 40'h1) else $error("complement wrong");
  round_bit_a: assert property (take && op_code == 3'h6
    |-> ##41 (result[0] && result_low == 40'h0)) else $error("round bit missing");
endmodule // shift_add_mul_checker
bind fixed_point_shift_add_mul shift_add_mul_checker chk_inst (.ref_clk(ref_clk),
  .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .operand_a(operand_a),
  .operand_b(operand_b), .shift_count(shift_count), .op_ready(op_ready),
  .result_valid(result_valid), .result(result), .result_low(result_low));
`default_nettype wire

// *** op_sequencer.sv ***
`default_nettype none
// ------------------------------
// Instruction sequencing model
// ------------------------------
module op_sequencer (
  input  wire logic        ref_clk,
  input  wire logic        op_ready,
  output logic             op_valid,
  output logic [2:0]       op_code,
  output logic [39:0]      operand_a,
  output logic [39:0]      operand_b,
  output logic [5:0]       shift_count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    op_valid = 1'b0;
    op_code = 3'h0;
    operand_a = 40'h0;
    operand_b = 40'h0;
    shift_count = 6'h0;
  end
  // Holds the request through the taking edge, releases at the next falling edge
  task automatic issue(input logic [2:0] c, input logic [39:0] a, b, input logic [5:0] n);
    @(negedge ref_clk);
    while (op_ready !== 1'b1) @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = c;
    operand_a = a;
    operand_b = b;
    shift_count = n;
    @(negedge ref_clk);
    op_valid = 1'b0;
  endtask
endmodule // op_sequencer
`default_nettype wire

// *** shift_bus_if.sv ***
`default_nettype none

interface shift_bus_if;
  logic [39:0] value;
  logic [5:0]  count;
  logic        right;
  logic [39:0] result;
  logic [39:0] spill;

  modport shifter (
    input  value,
    input  count,
    input  right,
    output result,
    output spill
  );

  modport user (
    output value,
    output count,
    output right,
    input  result,
    input  spill
  );
endinterface

`default_nettype wire

// *** shift_unit.sv ***
`include "fixed_point_consts.svh"
`default_nettype none

module shift_unit (
  shift_bus_if.shifter sb
);

  logic [5:0]  cnt;
  logic [79:0] stage [0:6];

  // ----------------------------------------------------------------
  // Count clamp and staging
  // ----------------------------------------------------------------
  // Counts above the maximum behave as the maximum
  assign cnt = (sb.count > `SHIFT_MAX) ? `SHIFT_MAX : sb.count; // RULE1

  // Whole word moves as one aggregate; right shift keeps spill below it
  assign stage[0] = sb.right ? {sb.value, 40'h00_0000_0000}
                             : {40'h00_0000_0000, sb.value}; // RULE5

  genvar k;
  generate
    for (k = 0; k < 6; k++) begin : g_stage
      localparam int SH = 1 << k;
      always_comb begin
        if (!cnt[k]) begin
          stage[k+1] = stage[k];
        end else if (sb.right) begin
          stage[k+1] = 80'($signed(stage[k]) >>> SH); // RULE3
        end else begin
          stage[k+1] = stage[k] << SH; // RULE2 RULE17
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Right: truncated word, lost bits offered MSB-aligned on spill
  assign sb.result = sb.right ? stage[6][79:40] : stage[6][39:0]; // RULE4
  assign sb.spill  = sb.right ? stage[6][39:0]  : stage[6][79:40]; // RULE4

endmodule // shift_unit

`default_nettype wire

// *** tb_top.sv ***
`default_nettype none
// ------------------------------
// Bench
// ------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  c;
    logic [39:0] a;
    logic [39:0] b;
    logic [5:0]  n;
  } row_t;
  logic        ref_clk;
  logic        rst_b;
  logic        op_valid;
  logic [2:0]  op_code;
  logic [39:0] operand_a;
  logic [39:0] operand_b;
  logic [5:0]  shift_count;
  logic        op_ready;
  logic        result_valid;
  logic [39:0] result;
  logic [39:0] result_low;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;
  row_t        rows [16];
  op_sequencer op_sequencer_inst (.ref_clk(ref_clk), .op_ready(op_ready), .op_valid(op_valid),
    .op_code(op_code), .operand_a(operand_a), .operand_b(operand_b), .shift_count(shift_count));
  fixed_point_shift_add_mul fixed_point_shift_add_mul_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .op_valid(op_valid), .op_code(op_code), .operand_a(operand_a), .operand_b(operand_b),
    .shift_count(shift_count), .op_ready(op_ready), .result_valid(result_valid),
    .result(result), .result_low(result_low));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Expected {result, result_low}; multiply reads sign plus 78 bits of the exact product
  function automatic logic [79:0] model(input row_t r);
    logic [79:0] w;
    logic [6:0]  k;
    k = (r.n > 6'h28) ? 7'h28 : {1'b0, r.n};
    w = $signed({{40{r.a[39]}}, r.a}) * $signed({{40{r.b[39]}}, r.b});
    case (r.c)
      3'h0: model = {({40'h0, r.a} << k) >> 40} | ({40'h0, r.a} << (k + 7'h28));
      3'h1: model = $signed({r.a, 40'h0}) >>> k;
      3'h2: model = {r.a + r.b, 40'h0};
      3'h3: model = {r.a - r.b, 40'h0};
      3'h4: model = {40'h0 - r.b, 40'h0};
      3'h5: model = {w[78:0], 1'b0};
      default: model = {w[78:40], 1'b1, 40'h0};
    endcase
  endfunction
  task automatic compare(input string what, input logic [79:0] e, input logic [79:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic run_op(input row_t r);
    op_sequencer_inst.issue(r.c, r.a, r.b, r.n);
    for (int i = 0; i < 60 && result_valid !== 1'b1; i++) @(negedge ref_clk);
    compare("answer valid", 80'h1, {79'h0, result_valid});
    compare("result pair", model(r), {result, result_low});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    rst_b = 1'b0;
    rows[0] = {3'h0, 40'hfa80000000, 40'h0, 6'h04};
    rows[1] = {3'h0, 40'h8000000001, 40'h0, 6'h28};
    rows[2] = {3'h0, 40'h5a00000003, 40'h0, 6'h3f};
    rows[3] = {3'h1, 40'haa80000000, 40'h0, 6'h04};
    rows[4] = {3'h1, 40'h8000000001, 40'h0, 6'h28};
    rows[5] = {3'h1, 40'h4000000003, 40'h0, 6'h01};
    rows[6] = {3'h2, 40'h7fffffffff, 40'h0000000001, 6'h0};
    rows[7] = {3'h2, 40'h8000000000, 40'hffffffffff, 6'h0};
    rows[8] = {3'h3, 40'h5680000000, 40'h6b00000000, 6'h0};
    rows[9] = {3'h4, 40'h0, 40'h8000000000, 6'h0};
    rows[10] = {3'h4, 40'h0, 40'h0, 6'h0};
    rows[11] = {3'h5, 40'h7000000000, 40'h9000000000, 6'h0};
    rows[12] = {3'h5, 40'h9000000000, 40'h9000000000, 6'h0};
    rows[13] = {3'h5, 40'hc000000000, 40'h6000000001, 6'h0};
    rows[14] = {3'h6, 40'h7000000000, 40'h9000000000, 6'h0};
    rows[15] = {3'h6, 40'h0000000001, 40'h0000000001, 6'h0};
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    foreach (rows[i]) run_op(rows[i]);
    $display("table test done");
    op_sequencer_inst.issue(3'h7, 40'h1, 40'h1, 6'h0);
    repeat (3) begin
      compare("silent code", 80'h0, {79'h0, result_valid});
      @(negedge ref_clk);
    end
    $display("unused code test done");
    // Reset in mid-multiply must abandon it and free the unit at once
    op_sequencer_inst.issue(3'h5, 40'hc000000000, 40'h6000000001, 6'h0);
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b0;
    @(negedge ref_clk);
    compare("reset words", 80'h0, {result, result_low});
    compare("reset flags", 80'h2, {78'h0, op_ready, result_valid});
    rst_b = 1'b1;
    run_op(rows[13]);
    $display("reset test done");
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
